/* File: common/ubc_pkg.sv */
// constants for the break control and branch trace block
package ubc_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_BREAK_CONTROL = 8'h00;
    localparam logic [7:0] ADR_EXEC_COUNT_B = 8'h04;
    localparam logic [7:0] ADR_SOURCE_TRACE = 8'h08;
    localparam logic [7:0] ADR_DEST_TRACE = 8'h0C;
    localparam logic [7:0] ADR_BUS_CYCLE_B = 8'h10;
    localparam logic [7:0] ADR_ASID_VALUES = 8'h14;

    // ------------------------------------------------------------
    // break control fields
    // ------------------------------------------------------------
    localparam int BIT_ASID_IGNORE_A = 21;
    localparam int BIT_ASID_IGNORE_B = 20;
    localparam int BIT_CPU_HIT_A = 15;
    localparam int BIT_CPU_HIT_B = 14;
    localparam int BIT_DMA_HIT_A = 13;
    localparam int BIT_DMA_HIT_B = 12;
    localparam int BIT_TRACE_ENABLE = 11;
    localparam int BIT_FETCH_TIMING_A = 10;
    localparam int BIT_DATA_COMPARE_B = 7;
    localparam int BIT_FETCH_TIMING_B = 6;
    localparam int BIT_CHAIN_SELECT = 3;
    localparam int BIT_COUNT_ENABLE_B = 0;
    localparam logic [31:0] BREAK_CONTROL_WMASK = 32'h0030_FCC9;
    localparam logic [31:0] BREAK_CONTROL_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // count, size and trace fields
    // ------------------------------------------------------------
    localparam int COUNT_W = 12;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 12'h000;
    localparam logic [COUNT_W-1:0] COUNT_LAST = 12'h001;
    localparam logic [1:0] SIZE_ANY = 2'h0;
    localparam logic [1:0] SIZE_RESET = 2'h0;
    localparam logic [15:0] ASID_RESET = 16'h0000;
    localparam int ASID_B_LSB = 8;
    localparam int TRACE_DEPTH = 8;
    localparam int TRACE_ADDR_W = 28;
    localparam int TRACE_PID_LSB = 28;
    localparam int TRACE_VALID_BIT = 31;

endpackage : ubc_pkg

/* File: hdl/user_break_control_trace.sv */
// break control, channel b counting and branch trace queues
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
// Overview of operation
// - channel b size field: 00 any, 01 byte, 10 word, 11 longword.
// - asid_ignore_a clear compares all eight asid bits on channel a.
// - asid_ignore_b clear compares all eight asid bits on channel b.
// - cpu cycle matches set cpu_hit_flag_a or _b; hardware never clears them.
// - dma cycle matches set dma_hit_flag_a or _b; hardware never clears them.
// - a hit flag clears only when software writes zero to it or on either reset.
// - trace_enable high records branches, low stops recording.
// - fetch_timing_a picks break before or after execution on channel a.
// - fetch_timing_b picks break before or after execution on channel b.
// - data_compare_enable_b adds data comparison to channel b condition.
// - chain_select zero makes channels independent, one makes them sequential.
// - count_enable_b makes channel b break only after counted matches.
// - each counted match decrements, holding at zero; break on match once count is one or zero.
// - execution count is twelve bits; upper twenty bits read zero.
// - reserved control bits read zero; writes to them are dropped.
// - source record keeps last address fetched before the branch.
// - source_valid sets on capture, clears on read and on resets.
// - source record bits 30 to 28 hold decode_buffer_pointer.
// - source records form an eight-entry queue shifting on each branch.
// - destination queue captures branch targets; dest_valid sets and clears likewise.
// - record contents other than valid flags survive both resets.
// - destination record holds first fetched address and dest_valid in bit 31.
// - satisfied break conditions raise a break request to the interrupt controller.
// - sequential mode ignores b before a, and simultaneous a and b.
module user_break_control_trace (
    // clock and resets
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic manual_rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // observed bus cycle
    input wire logic cyc_valid,
    input wire logic cyc_is_dma,
    input wire logic cyc_is_fetch,
    input wire logic [1:0] cyc_size,
    input wire logic [7:0] cyc_asid,
    input wire logic addr_match_a,
    input wire logic addr_match_b,
    input wire logic data_match_b,
    // branch events
    input wire logic branch_event,
    input wire logic [27:0] branch_src_addr,
    input wire logic [2:0] branch_pid,
    input wire logic [27:0] branch_dst_addr,
    // break request
    output logic break_req,
    output logic break_post_exec,
    output logic break_on_b
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
            input logic [31:0] new_v, input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    // ------------------------------------------------------------
    // manual reset synchroniser
    // ------------------------------------------------------------
    logic mrst_meta_q;
    logic mrst_sync_q;
    always_ff @(posedge mclk) begin
        mrst_meta_q <= manual_rst;
        mrst_sync_q <= mrst_meta_q;
    end
    logic rst;
    assign rst = sys_rst | mrst_sync_q;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic acc, wr, rd;
    assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr = acc & wb_we_i;
    assign rd = acc & ~wb_we_i;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] ctl_q, ctl_d;
    logic [ubc_pkg::COUNT_W-1:0] cnt_q, cnt_d;
    logic [1:0] size_b_q, size_b_d;
    logic [15:0] asid_q, asid_d;
    logic armed_q, armed_d;
    logic brk_q, brk_d;
    logic post_q, post_d;
    logic onb_q, onb_d;

    // ------------------------------------------------------------
    // match conditions
    // ------------------------------------------------------------
    logic asid_ok_a, asid_ok_b, size_ok_b, data_ok_b;
    logic cond_a, cond_b, hit_b, count_ok, fire_a, fire_b;
    logic [31:0] wmerged, cnt_word, size_word, asid_word;

    assign asid_ok_a = ctl_q[ubc_pkg::BIT_ASID_IGNORE_A] | (cyc_asid == asid_q[7:0]);
    assign asid_ok_b = ctl_q[ubc_pkg::BIT_ASID_IGNORE_B]
        | (cyc_asid == asid_q[ubc_pkg::ASID_B_LSB +: 8]);
    assign size_ok_b = (size_b_q == ubc_pkg::SIZE_ANY) | (size_b_q == cyc_size);
    assign data_ok_b = ~ctl_q[ubc_pkg::BIT_DATA_COMPARE_B] | cyc_is_fetch | data_match_b;
    assign cond_a = cyc_valid & addr_match_a & asid_ok_a;
    assign cond_b = cyc_valid & addr_match_b & asid_ok_b & size_ok_b & data_ok_b;

    assign hit_b = ctl_q[ubc_pkg::BIT_CHAIN_SELECT] ? (cond_b & armed_q & ~cond_a) : cond_b;
    assign count_ok = ~ctl_q[ubc_pkg::BIT_COUNT_ENABLE_B] | (cnt_q <= ubc_pkg::COUNT_LAST);
    // a breaks alone only when independent
    assign fire_a = cond_a & ~ctl_q[ubc_pkg::BIT_CHAIN_SELECT];
    assign fire_b = hit_b & count_ok;
    assign wmerged = merge_bytes(ctl_q, wb_dat_i, wb_sel_i);
    // narrow registers merge through a full word, then get sliced
    assign cnt_word = merge_bytes({20'h0_0000, cnt_q}, wb_dat_i, wb_sel_i);
    assign size_word = merge_bytes({30'h0000_0000, size_b_q}, wb_dat_i, wb_sel_i);
    assign asid_word = merge_bytes({16'h0000, asid_q}, wb_dat_i, wb_sel_i);

    always_comb begin
        ctl_d = ctl_q;
        cnt_d = cnt_q;
        size_b_d = size_b_q;
        asid_d = asid_q;
        armed_d = armed_q;
        if (wr && wb_adr_i == ubc_pkg::ADR_BREAK_CONTROL) begin
            ctl_d = wmerged & ubc_pkg::BREAK_CONTROL_WMASK;
            // writing one never sets a flag
            ctl_d[15:12] = ctl_q[15:12] & wmerged[15:12];
        end
        if (wr && wb_adr_i == ubc_pkg::ADR_EXEC_COUNT_B) begin
            cnt_d = cnt_word[ubc_pkg::COUNT_W-1:0];
        end
        if (wr && wb_adr_i == ubc_pkg::ADR_BUS_CYCLE_B) begin
            size_b_d = size_word[1:0];
        end
        if (wr && wb_adr_i == ubc_pkg::ADR_ASID_VALUES) begin
            asid_d = asid_word[15:0];
        end
        if (cond_a && !cyc_is_dma) begin
            ctl_d[ubc_pkg::BIT_CPU_HIT_A] = 1'b1;
        end
        if (cond_b && !cyc_is_dma) begin
            ctl_d[ubc_pkg::BIT_CPU_HIT_B] = 1'b1;
        end
        if (cond_a && cyc_is_dma) begin
            ctl_d[ubc_pkg::BIT_DMA_HIT_A] = 1'b1;
        end
        if (cond_b && cyc_is_dma) begin
            ctl_d[ubc_pkg::BIT_DMA_HIT_B] = 1'b1;
        end
        if (hit_b && ctl_q[ubc_pkg::BIT_COUNT_ENABLE_B] && cnt_q != ubc_pkg::COUNT_RESET) begin
            cnt_d = cnt_q - ubc_pkg::COUNT_LAST;
        end
        // sequencing arms on a, drops after b break
        if (!ctl_q[ubc_pkg::BIT_CHAIN_SELECT]) begin
            armed_d = 1'b0;
        end else if (cond_a) begin
            armed_d = 1'b1;
        end else if (fire_b) begin
            armed_d = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // break request
    // ------------------------------------------------------------
    always_comb begin
        brk_d = fire_a | fire_b;
        onb_d = fire_b & ~fire_a;
        post_d = 1'b0;
        if (fire_a && cyc_is_fetch) begin
            post_d = ctl_q[ubc_pkg::BIT_FETCH_TIMING_A];
        end else if (fire_b && cyc_is_fetch) begin
            post_d = ctl_q[ubc_pkg::BIT_FETCH_TIMING_B];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctl_q <= ubc_pkg::BREAK_CONTROL_RESET;
            cnt_q <= ubc_pkg::COUNT_RESET;
            size_b_q <= ubc_pkg::SIZE_RESET;
            asid_q <= ubc_pkg::ASID_RESET;
            armed_q <= 1'b0;
            brk_q <= 1'b0;
            post_q <= 1'b0;
            onb_q <= 1'b0;
        end else begin
            ctl_q <= ctl_d;
            cnt_q <= cnt_d;
            size_b_q <= size_b_d;
            asid_q <= asid_d;
            armed_q <= armed_d;
            brk_q <= brk_d;
            post_q <= post_d;
            onb_q <= onb_d;
        end
    end

    // ------------------------------------------------------------
    // branch trace queues
    // ------------------------------------------------------------
    // entry 0 is newest; a read pops it so software can walk all eight
    logic [30:0] src_q [ubc_pkg::TRACE_DEPTH];
    logic [30:0] src_d [ubc_pkg::TRACE_DEPTH];
    logic [27:0] dst_q [ubc_pkg::TRACE_DEPTH];
    logic [27:0] dst_d [ubc_pkg::TRACE_DEPTH];
    logic [ubc_pkg::TRACE_DEPTH-1:0] sval_q, sval_d, dval_q, dval_d;
    logic capture, pop_src, pop_dst;

    assign capture = branch_event & ctl_q[ubc_pkg::BIT_TRACE_ENABLE];
    assign pop_src = rd & (wb_adr_i == ubc_pkg::ADR_SOURCE_TRACE);
    assign pop_dst = rd & (wb_adr_i == ubc_pkg::ADR_DEST_TRACE);

    always_comb begin
        src_d = src_q;
        dst_d = dst_q;
        sval_d = sval_q;
        dval_d = dval_q;
        if (pop_src) begin
            sval_d[0] = 1'b0;
        end
        if (pop_dst) begin
            dval_d[0] = 1'b0;
        end
        if (capture) begin
            for (int i = ubc_pkg::TRACE_DEPTH - 1; i > 0; i--) begin
                src_d[i] = src_q[i-1];
                dst_d[i] = dst_q[i-1];
                sval_d[i] = sval_d[i-1];
                dval_d[i] = dval_d[i-1];
            end
            src_d[0] = {branch_pid, branch_src_addr};
            dst_d[0] = branch_dst_addr;
            sval_d[0] = 1'b1;
            dval_d[0] = 1'b1;
        end else begin
            if (pop_src) begin
                for (int i = 0; i < ubc_pkg::TRACE_DEPTH - 1; i++) begin
                    src_d[i] = src_q[i+1];
                    sval_d[i] = sval_q[i+1];
                end
                sval_d[ubc_pkg::TRACE_DEPTH-1] = 1'b0;
            end
            if (pop_dst) begin
                for (int i = 0; i < ubc_pkg::TRACE_DEPTH - 1; i++) begin
                    dst_d[i] = dst_q[i+1];
                    dval_d[i] = dval_q[i+1];
                end
                dval_d[ubc_pkg::TRACE_DEPTH-1] = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        src_q <= src_d;
        dst_q <= dst_d;
    end

    // valid flags cleared by either reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            sval_q <= '0;
            dval_q <= '0;
        end else begin
            sval_q <= sval_d;
            dval_q <= dval_d;
        end
    end

    // ------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------
    always_comb begin
        ack_d = acc;
        rdat_d = 32'h0000_0000;
        if (rd) begin
            unique case (wb_adr_i)
                ubc_pkg::ADR_BREAK_CONTROL: rdat_d = ctl_q;
                ubc_pkg::ADR_EXEC_COUNT_B: rdat_d = {20'h0_0000, cnt_q};
                ubc_pkg::ADR_SOURCE_TRACE: rdat_d = {sval_q[0], src_q[0]};
                ubc_pkg::ADR_DEST_TRACE: rdat_d = {dval_q[0], 3'h0, dst_q[0]};
                ubc_pkg::ADR_BUS_CYCLE_B: rdat_d = {30'h0000_0000, size_b_q};
                ubc_pkg::ADR_ASID_VALUES: rdat_d = {16'h0000, asid_q};
                default: rdat_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign break_req = brk_q;
    assign break_post_exec = post_q;
    assign break_on_b = onb_q;

endmodule : user_break_control_trace

/* File: tb/bus_source_model.sv */
// far-side model: cpu and dma bus cycles plus branch events
`timescale 1ns/1ps
module bus_source_model (
    // bench control
    input wire logic mclk,
    input wire logic fire,
    input wire logic [15:0] cmd,
    input wire logic [27:0] src,
    input wire logic [2:0] pid,
    input wire logic [27:0] dst,
    // observed cycle and branch
    output logic cyc_valid,
    output logic branch_event,
    output logic cyc_is_dma,
    output logic cyc_is_fetch,
    output logic [1:0] cyc_size,
    output logic [7:0] cyc_asid,
    output logic addr_match_a,
    output logic addr_match_b,
    output logic data_match_b,
    output logic [27:0] branch_src_addr,
    output logic [2:0] branch_pid,
    output logic [27:0] branch_dst_addr
);
    logic [75:0] v_q = '0;
    // idle fields flip every cycle, so stale values never pass as live
    always @(posedge mclk) begin
        v_q <= {fire && !cmd[0], fire && cmd[0], fire ? {cmd[15:1], src, pid, dst} : ~v_q[73:0]};
    end
    assign {cyc_valid, branch_event, cyc_is_dma, cyc_is_fetch, cyc_size, cyc_asid} = v_q[75:62];
    assign {addr_match_a, addr_match_b, data_match_b} = v_q[61:59];
    assign {branch_src_addr, branch_pid, branch_dst_addr} = v_q[58:0];
endmodule : bus_source_model

/* File: tb/tb_top.sv */
// self-checking bench for the break control and trace block
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic mclk = 0, sys_rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, fire = 0;
    logic manual_rst = 0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rv, ed;
    logic [31:0] es [2];
    logic [15:0] cmd = 16'h0, rnd = 16'h000B;
    logic [27:0] src = 28'h0, dst = 28'h0, branch_src_addr, branch_dst_addr;
    logic [2:0] pid = 3'h0, r, branch_pid;
    logic [1:0] cyc_size;
    logic [7:0] cyc_asid;
    logic wb_ack_o, cyc_valid, cyc_is_dma, cyc_is_fetch, addr_match_a, addr_match_b;
    logic data_match_b, branch_event, break_req, break_post_exec, break_on_b;
    int fails = 0, n_tests = 0, cnt = 0;
    always #2 mclk = ~mclk;
    user_break_control_trace i_user_break_control_trace (.mclk, .sys_rst, .manual_rst,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .cyc_valid, .cyc_is_dma, .cyc_is_fetch, .cyc_size, .cyc_asid, .addr_match_a,
        .addr_match_b, .data_match_b, .branch_event, .branch_src_addr, .branch_pid,
        .branch_dst_addr, .break_req, .break_post_exec, .break_on_b);
    bus_source_model i_bus_source_model (.mclk, .fire, .cmd, .src, .pid, .dst, .cyc_valid,
        .branch_event, .cyc_is_dma, .cyc_is_fetch, .cyc_size, .cyc_asid, .addr_match_a,
        .addr_match_b, .data_match_b, .branch_src_addr, .branch_pid, .branch_dst_addr);
    // ------------------------------------------------------------
    // tasks and functions
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [31:0] src_rec(input logic [15:0] x);
        return {1'b1, x[2:0], x[11:0], x};
    endfunction : src_rec
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge mclk);
        while (wb_ack_o !== 1'b1) @(posedge mclk);
        rv = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    // result is {from b, post execution, break seen}
    task automatic hit(input logic [15:0] c);
        @(posedge mclk);
        cmd <= c;
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
        r = 3'b000;
        repeat (4) begin
            @(posedge mclk);
            if (break_req === 1'b1) r = {break_on_b, break_post_exec, 1'b1};
        end
    endtask : hit
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    // hang guard, far above the few hundred cycles needed
    always @(posedge mclk) begin
        cnt++;
        if (cnt == 5000) begin
            fails++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        wb(0, 8'h00, 0); `CHK(rv, 32'h0)
        wb(1, 8'h00, 32'hFFFF_FFFF); wb(0, 8'h00, 0); `CHK(rv, 32'h0030_0CC9)
        wb(1, 8'h04, 32'hFFFF_FFFF); wb(0, 8'h04, 0); `CHK(rv, 32'h0000_0FFF)
        wb(0, 8'h40, 0); `CHK(rv, 32'h0)
        $display("test registers done");
        wb(1, 8'h00, 32'h0030_0000); hit(16'h0008); `CHK(r, 3'b001)
        wb(0, 8'h00, 0); `CHK(rv, 32'h0030_8000)
        hit(16'h8004); `CHK(r, 3'b101)
        wb(0, 8'h00, 0); `CHK(rv, 32'h0030_9000)
        wb(1, 8'h00, 32'h0030_0000); wb(0, 8'h00, 0); `CHK(rv, 32'h0030_0000)
        wb(1, 8'h00, 32'h0030_0400); hit(16'h4008); `CHK(r, 3'b011)
        wb(1, 8'h00, 32'h0030_0040); hit(16'h4004); `CHK(r, 3'b111)
        wb(1, 8'h00, 32'h0030_0080); hit(16'h0004); `CHK(r, 3'b000)
        hit(16'h0006); `CHK(r, 3'b101)
        $display("test flags and timing done");
        rnd = lfsr(rnd);
        wb(1, 8'h00, 0); wb(1, 8'h14, {24'h0, rnd[7:0]});
        hit({4'h0, rnd[7:0], 4'h8}); `CHK(r, 3'b001)
        hit({4'h0, rnd[7:0] ^ 8'h01, 4'h8}); `CHK(r, 3'b000)
        wb(1, 8'h14, {16'h0, rnd[7:0], 8'h00});
        hit({4'h0, rnd[7:0] ^ 8'h80, 4'h4}); `CHK(r, 3'b000)
        wb(1, 8'h00, 32'h0010_0000);
        hit({4'h0, rnd[7:0] ^ 8'h80, 4'h4}); `CHK(r, 3'b101)
        for (int s = 1; s < 4; s++) begin
            wb(1, 8'h10, 32'(s));
            hit({2'h0, s[1:0], 12'h004}); `CHK(r, 3'b101)
            hit({2'h0, (s == 3) ? 2'h1 : 2'(s + 1), 12'h004}); `CHK(r, 3'b000)
        end
        wb(1, 8'h10, 0);
        $display("test asid and size done");
        wb(1, 8'h00, 32'h0030_0001); wb(1, 8'h04, 32'h3);
        hit(16'h0004); `CHK(r, 3'b000)
        hit(16'h0004); `CHK(r, 3'b000)
        wb(0, 8'h04, 0); `CHK(rv, 32'h1)
        hit(16'h0004); `CHK(r, 3'b101)
        wb(1, 8'h00, 32'h0030_0008); hit(16'h0004); `CHK(r, 3'b000)
        hit(16'h000C); `CHK(r, 3'b000)
        hit(16'h0004); `CHK(r[0], 1'b1)
        $display("test count and sequence done");
        wb(1, 8'h00, 32'h0030_0000); hit(16'h0001); wb(0, 8'h08, 0); `CHK(rv[31], 1'b0)
        wb(1, 8'h00, 32'h0030_0800);
        for (int i = 0; i < 2; i++) begin
            rnd = lfsr(rnd);
            src <= {rnd[11:0], rnd};
            pid <= rnd[2:0];
            dst <= {rnd, ~rnd[11:0]};
            es[i] = src_rec(rnd);
            ed = {4'h8, rnd, ~rnd[11:0]};
            hit(16'h0001);
        end
        wb(0, 8'h08, 0); `CHK(rv, es[1])
        wb(0, 8'h08, 0); `CHK(rv, es[0])
        wb(0, 8'h0C, 0); `CHK(rv, ed)
        wb(0, 8'h08, 0); `CHK(rv[31], 1'b0)
        // manual reset mid-run: valid flag drops, record bits survive
        rnd = lfsr(rnd);
        src <= {rnd[11:0], rnd};
        pid <= rnd[2:0];
        es[0] = src_rec(rnd);
        hit(16'h0001);
        manual_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        manual_rst <= 1'b0;
        repeat (4) @(posedge mclk);
        wb(0, 8'h08, 0); `CHK(rv, {1'b0, es[0][30:0]})
        wb(0, 8'h00, 0); `CHK(rv, 32'h0)
        $display("test trace done");
        report_and_stop();
    end
endmodule : tb_top

/* File: tb/user_break_control_trace_properties.sv */
// checker for the break control and trace block
`timescale 1ns/1ps
module ubc_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // match side
    input wire logic cyc_valid,
    input wire logic cyc_is_fetch,
    input wire logic addr_match_b,
    input wire logic break_req,
    input wire logic break_post_exec,
    input wire logic break_on_b
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_ctrl_rsvd_zero: assert property (wb_ack_o && $past(wb_adr_i) == 8'h00
        |-> (wb_dat_o & ~ubc_pkg::BREAK_CONTROL_WMASK) == 32'h0)
        else $error("reserved control bits not zero");
    a_count_upper_zero: assert property (wb_ack_o && $past(wb_adr_i) == 8'h04
        |-> wb_dat_o[31:12] == 20'h0)
        else $error("count upper bits not zero");
    a_dest_rsvd_zero: assert property (wb_ack_o && $past(wb_adr_i) == 8'h0C
        |-> wb_dat_o[30:28] == 3'h0)
        else $error("destination reserved bits not zero");
    a_break_has_cause: assert property (break_req |-> $past(cyc_valid))
        else $error("break without bus cycle");
    a_post_needs_fetch: assert property (break_post_exec |-> break_req && $past(cyc_is_fetch))
        else $error("post break without fetch");
    a_b_break_cause: assert property (break_on_b |-> break_req && $past(addr_match_b))
        else $error("channel b break without b match");
    a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !break_req && !wb_ack_o)
        else $error("output active in reset");
endmodule : ubc_checker
bind user_break_control_trace ubc_checker i_chk (.mclk(mclk), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cyc_valid(cyc_valid), .cyc_is_fetch(cyc_is_fetch),
    .addr_match_b(addr_match_b), .break_req(break_req), .break_post_exec(break_post_exec),
    .break_on_b(break_on_b));
